// ### srtr_pkg.sv
/*
  types shared by the set/reset latch and toggle relay block.
  assumes srtr_regs.svh is on the include path.
*/
`include "srtr_regs.svh"

package srtr_pkg;

  // priority choice of the toggle relay when set and reset are both high
  typedef enum logic {
    reset_wins_choice = `SRTR_PRIO_RESET_WINS,
    set_wins_choice = `SRTR_PRIO_SET_WINS
  } srtr_prio_e;

  // inputs of the latch element
  typedef struct packed {
    logic set;
    logic rst;
    logic retain;
  } srtr_latch_in_s;

  // inputs of the toggle relay element
  typedef struct packed {
    logic trg;
    logic set;
    logic rst;
    logic retain;
    srtr_prio_e prio;
  } srtr_toggle_in_s;

  // evaluation sequencer, gray coded along wait -> eval
  typedef enum logic [1:0] {
    srtr_st_wait = 2'h0,
    srtr_st_eval = 2'h1
  } srtr_state_e;

endpackage

// ### srtr_regs.svh
/*
  timing and reset constants for the set/reset latch and toggle relay pair.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef SRTR_REGS_SVH
`define SRTR_REGS_SVH

// controller evaluation period in ns and the cycle count derived from it
`define SRTR_EVAL_PERIOD_NS 1000
`define SRTR_CLK_PERIOD_NS 50
`define SRTR_EVAL_CYCLES ((`SRTR_EVAL_PERIOD_NS) / (`SRTR_CLK_PERIOD_NS))
`define SRTR_DIV_W 5

// reset values of the state flip-flops
`define SRTR_LATCH_RST 1'b0
`define SRTR_TOGGLE_RST 1'b0
`define SRTR_TRG_RST 1'b0

// priority encoding
`define SRTR_PRIO_RESET_WINS 1'b0
`define SRTR_PRIO_SET_WINS 1'b1

`endif

// ### srtr_relay.sv
/*
  set/reset latch (reset dominant) and toggle relay with selectable priority,
  both evaluated once per controller cycle.
  assumes inputs come from other logic on ref_clk and that preserved values
  for retention are supplied from a retentive store by the surrounding logic.
*/
`timescale 1ns/1ps
`include "srtr_regs.svh"

module srtr_relay (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire srtr_pkg::srtr_latch_in_s latch_in,
  input wire srtr_pkg::srtr_toggle_in_s toggle_in,
  input wire logic latch_saved,
  input wire logic toggle_saved,
  output logic latch_q,
  output logic toggle_q,
  output logic eval_tick
);

  // ************************************************
  // evaluation divider
  // ************************************************
  localparam logic [`SRTR_DIV_W-1:0] EVAL_LAST = `SRTR_DIV_W'(`SRTR_EVAL_CYCLES - 1);

  logic [`SRTR_DIV_W-1:0] div_r, div_nxt;
  srtr_pkg::srtr_state_e st_r, st_nxt;

  // a single cycle of ref_clk per controller cycle carries the evaluation
  always_comb begin
    div_nxt = (div_r == EVAL_LAST) ? '0 : div_r + `SRTR_DIV_W'(1);
    st_nxt = (div_r == EVAL_LAST) ? srtr_pkg::srtr_st_eval : srtr_pkg::srtr_st_wait;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      st_r <= srtr_pkg::srtr_st_wait;
    end else begin
      div_r <= div_nxt;
      st_r <= st_nxt;
    end
  end

  always_comb begin
    case (st_r)
      srtr_pkg::srtr_st_eval: eval_tick = 1'b1;
      default: eval_tick = 1'b0;
    endcase
  end

  // ************************************************
  // power-up restore
  // ************************************************
  // async reset may only load constants, so retained values are loaded at the
  // first edge after release; a flag marks that load as pending
  logic restore_r, restore_nxt;

  always_comb begin
    restore_nxt = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      restore_r <= 1'b1;
    end else begin
      restore_r <= restore_nxt;
    end
  end

  // ************************************************
  // latch element
  // ************************************************
  logic latch_r, latch_nxt;

  always_comb begin
    latch_nxt = latch_r;
    if (restore_r) begin
      latch_nxt = latch_in.retain ? latch_saved : `SRTR_LATCH_RST;
    end else if (eval_tick) begin
      if (latch_in.rst) begin
        latch_nxt = 1'b0; // reset dominates
      end else if (latch_in.set) begin
        latch_nxt = 1'b1;
      end // both low holds
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= `SRTR_LATCH_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  assign latch_q = latch_r;

  // ************************************************
  // toggle relay element
  // ************************************************
  logic tog_r, tog_nxt;
  logic trg_prev_r, trg_prev_nxt;
  logic trg_rise;

  // edge seen only against the previous evaluation sample, so a steady level
  // never toggles however long it is held
  assign trg_rise = toggle_in.trg & ~trg_prev_r;

  always_comb begin
    tog_nxt = tog_r;
    trg_prev_nxt = trg_prev_r;
    if (restore_r) begin
      tog_nxt = toggle_in.retain ? toggle_saved : `SRTR_TOGGLE_RST;
      trg_prev_nxt = toggle_in.trg; // no spurious edge right after power-up
    end else if (eval_tick) begin
      trg_prev_nxt = toggle_in.trg;
      if (toggle_in.set && toggle_in.rst) begin
        tog_nxt = (toggle_in.prio == srtr_pkg::set_wins_choice);
      end else if (toggle_in.set) begin
        tog_nxt = 1'b1;
      end else if (toggle_in.rst) begin
        tog_nxt = 1'b0;
      end else if (trg_rise) begin
        tog_nxt = ~tog_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_r <= `SRTR_TOGGLE_RST;
      trg_prev_r <= `SRTR_TRG_RST;
    end else begin
      tog_r <= tog_nxt;
      trg_prev_r <= trg_prev_nxt;
    end
  end

  assign toggle_q = tog_r;

  // ************************************************
  // checks
  // ************************************************
  a_latch_reset_dom: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r && latch_in.rst) |=> !latch_q)
    else $error("latch not low after reset input");

  a_latch_set_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r && latch_in.set && !latch_in.rst) |=> latch_q)
    else $error("latch not high after set alone");

  a_latch_hold_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!restore_r && !latch_in.set && !latch_in.rst) |=> $stable(latch_q))
    else $error("latch changed with inputs idle");

  // rst_n in the antecedent is the sampled level, so the release edge itself
  // starts no attempt while the flops are still held in reset
  a_latch_restore_val: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rst_n && restore_r) |=> (latch_q == ($past(latch_in.retain) ? $past(latch_saved) : 1'b0)))
    else $error("latch power-up value wrong");

  a_toggle_edge_flip: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r && !toggle_in.set && !toggle_in.rst && toggle_in.trg && !trg_prev_r)
      |=> (toggle_q != $past(toggle_q)))
    else $error("toggle missed a trigger edge");

  a_toggle_set_force: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r && toggle_in.set && !toggle_in.rst) |=> toggle_q)
    else $error("toggle not forced high by set");

  // a trigger edge under set or reset must leave only the forced level behind
  a_toggle_edge_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r && (toggle_in.set || toggle_in.rst) && toggle_in.trg && !trg_prev_r)
      |=> (toggle_q == ($past(toggle_in.set)
        && (!$past(toggle_in.rst) || $past(toggle_in.prio) == srtr_pkg::set_wins_choice))))
    else $error("toggle followed a masked trigger edge");

  a_toggle_reset_force: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r && toggle_in.rst && !toggle_in.set) |=> !toggle_q)
    else $error("toggle not forced low by reset");

  a_toggle_prio_both: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r && toggle_in.set && toggle_in.rst)
      |=> (toggle_q == ($past(toggle_in.prio) == srtr_pkg::set_wins_choice)))
    else $error("toggle priority result wrong");

  a_toggle_restore_val: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rst_n && restore_r) |=> (toggle_q == ($past(toggle_in.retain) ? $past(toggle_saved) : 1'b0)))
    else $error("toggle power-up value wrong");

  a_toggle_latch_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r && !toggle_in.trg && toggle_in.prio == srtr_pkg::reset_wins_choice
      && toggle_in.set == latch_in.set && toggle_in.rst == latch_in.rst && (toggle_in.set || toggle_in.rst))
      |=> (toggle_q == latch_q))
    else $error("toggle differs from latch");

  a_steady_trg_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!restore_r && !toggle_in.set && !toggle_in.rst && toggle_in.trg == trg_prev_r) |=> $stable(toggle_q))
    else $error("toggle changed on steady trigger");

  a_eval_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
    eval_tick |=> !eval_tick)
    else $error("evaluation pulses back to back");

  a_trg_history: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (eval_tick && !restore_r) |=> (trg_prev_r == $past(toggle_in.trg)))
    else $error("trigger history not updated");

  // restore lasts one cycle and seeds the trigger history from the live level
  a_restore_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rst_n && restore_r) |=> (!restore_r && trg_prev_r == $past(toggle_in.trg)))
    else $error("power-up restore wrong");

endmodule

// ### srtr_relay_bench.sv
/*
  row-driven bench for the latch and toggle relay pair.
  assumes srtr_pkg and srtr_relay are compiled first.
*/
`timescale 1ns/1ps

module srtr_relay_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  srtr_pkg::srtr_latch_in_s latch_in = '0;
  srtr_pkg::srtr_toggle_in_s toggle_in = '0;
  logic latch_saved = 1'b0;
  logic toggle_saved = 1'b0;
  logic latch_q, toggle_q, eval_tick;
  int n_mismatch = 0;
  int checks = 0;
  int gap;
  // row bits: lset lrst trg tset trst prio, then latch and toggle expected
  logic [7:0] rows [12] = '{8'h93, 8'h03, 8'h22, 8'h22, 8'h02, 8'h23,
                            8'hd8, 8'hfd, 8'h48, 8'h68, 8'h20, 8'h93};

  srtr_relay uut (.ref_clk(ref_clk), .rst_n(rst_n), .latch_in(latch_in), .toggle_in(toggle_in),
    .latch_saved(latch_saved), .toggle_saved(toggle_saved), .latch_q(latch_q),
    .toggle_q(toggle_q), .eval_tick(eval_tick));

  // 50 ns period
  always #25 ref_clk = ~ref_clk;

  // ****************
  // helper tasks
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // bounded wait for the next evaluation edge, then settle past it
  task automatic take_eval();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (eval_tick !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 40)
      check(1'b0, 1'b1);
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // power loss with chosen retention; trg stays high so restore must not count an edge
  task automatic pwr_loss(input logic rl, rt, sl, st, el, et);
    @(posedge ref_clk);
    latch_in <= '{1'b0, 1'b0, rl};
    toggle_in <= '{1'b1, 1'b0, 1'b0, rt, srtr_pkg::reset_wins_choice};
    latch_saved <= sl;
    toggle_saved <= st;
    rst_n <= 1'b0;
    @(negedge ref_clk);
    check({latch_q, toggle_q, eval_tick}, 3'h0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    check(latch_q, el);
    check(toggle_q, et);
    take_eval();
    check(toggle_q, et);
    $display("power loss test done");
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge ref_clk);
      latch_in <= '{rows[i][7], rows[i][6], 1'b0};
      toggle_in <= '{rows[i][5], rows[i][4], rows[i][3], 1'b0, srtr_pkg::srtr_prio_e'(rows[i][2])};
      take_eval();
      check(latch_q, rows[i][1]);
      check(toggle_q, rows[i][0]);
      $display("row %0d done", i);
    end
    // evaluation spacing, reckoned between two ticks
    take_eval();
    gap = 1;
    while (eval_tick !== 1'b1 && gap < 40) begin
      @(negedge ref_clk);
      gap++;
    end
    check(gap, 32'h14);
    $display("spacing test done");
    // retained toggle value of one, so a kept value differs from a cleared one
    pwr_loss(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    pwr_loss(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    conclude();
  end

  // watchdog, well beyond the expected few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule
